// ### cfgs_sequencer.v
// Purpose: device-side sequencer for byte-wide parallel configuration loading
// Assumes: host pins are asynchronous and pass two flops; 100 MHz clk
// Notes:   status and complete lines are open drain, oe low means pulling low
//
// Function
// - in user mode all three lines high; request low starts reconfiguration
// - status held low for whole power-on-reset delay after power-up
// - complete line low from power-up until configuration finishes
// - every status low pulse lasts at least 10 us
// - status released within 500 us after request returns high
// - release limit excludes external holding of the shared status line
// - internal oscillator: user mode no sooner than 55 us after complete
// - 55 us bound applies only with internal oscillator start-up
// - user init clock used no sooner than four max strobe periods after complete
// - user mode 8532 user init clock periods after that clock is enabled
// - data pins become user io per dual-purpose setting after configuration
// - on error drive status low and reset internally
// - request low pulls status and complete low, tristates all io
`timescale 1ns/1ns
`default_nettype none
`include "cfgs_defs.vh"

module cfgs_sequencer #(
  parameter POR_CYC     = `CFGS_POR_CYC,     // power-on-reset hold, cycles
  parameter CD2UM_CYC   = `CFGS_CD2UM_CYC,   // complete to user mode, cycles
  parameter USR_PERIODS = `CFGS_USR_PERIODS, // user init clock periods
  parameter IMAGE_BYTES = `CFGS_IMAGE_BYTES  // bytes in one image
) (
  input  wire       clk,               // system clock, 100 MHz
  input  wire       rstn,              // power-on reset, async, active low
  input  wire       config_request_n,  // host request pin, active low
  input  wire       load_strobe_clock, // host data strobe pin
  input  wire       user_init_clock,   // optional user init clock pin
  input  wire [7:0] data_in,           // data bus pins, input side
  output reg  [7:0] data_out,          // data bus pins, output side
  output reg        data_oe_n,         // data bus drive, low drives
  input  wire       status_in,         // status line level
  output wire       status_out,        // status line drive value
  output reg        status_oe_n,       // status line drive, low pulls low
  input  wire       complete_in,       // complete line level (unused read)
  output wire       complete_out,      // complete line drive value
  output reg        complete_oe_n,     // complete line drive, low pulls low
  input  wire       opt_user_init_clk, // start-up from user init clock
  input  wire       opt_auto_restart,  // release status after error
  input  wire       dual_purpose_io,   // data pins usable as user io
  input  wire       byte_error,        // image checker flags error
  input  wire [7:0] user_io_out,       // user logic drive value
  input  wire       user_io_oe,        // user logic drive request
  output reg  [7:0] cfg_byte,          // captured configuration byte
  output reg        cfg_byte_valid,    // one-cycle pulse per byte
  output reg        user_mode,         // device is in user mode
  output reg        io_tristate        // all user io tristated
);

  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [3:0] ST_POR      = 4'h0;
  localparam [3:0] ST_RESET    = 4'h1;
  localparam [3:0] ST_RELEASE  = 4'h2;
  localparam [3:0] ST_LOAD     = 4'h3;
  localparam [3:0] ST_INIT_OSC = 4'h4;
  localparam [3:0] ST_INIT_CU  = 4'h5;
  localparam [3:0] ST_INIT_USR = 4'h6;
  localparam [3:0] ST_USER     = 4'h7;
  localparam [3:0] ST_ERROR    = 4'h8;
  localparam [3:0] ST_ERR_HOLD = 4'h9;

  localparam TW = `CFGS_TMR_W;
  // counts start as integers and are cut to the timer or byte counter width on purpose
  localparam integer  POR_I    = POR_CYC;
  localparam integer  STATUS_I = `CFGS_STATUS_MIN_CYC;
  localparam integer  CD2UM_I  = CD2UM_CYC;
  localparam integer  CU_I     = `CFGS_CU_CYC;
  localparam integer  USR_I    = USR_PERIODS;
  localparam integer  LAST_I   = IMAGE_BYTES - 1;
  localparam [TW-1:0] T_POR    = POR_I[TW-1:0];
  localparam [TW-1:0] T_STATUS = STATUS_I[TW-1:0];
  localparam [TW-1:0] T_CD2UM  = CD2UM_I[TW-1:0];
  localparam [TW-1:0] T_CU     = CU_I[TW-1:0];
  localparam [TW-1:0] T_USR    = USR_I[TW-1:0];
  localparam [15:0]   LAST_IDX = LAST_I[15:0];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire       req_n_s;
  wire       strobe_s;
  wire       uclk_s;
  wire       status_s;
  wire [7:0] data_s;

  cfgs_sync #(.W(12)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({config_request_n, load_strobe_clock, user_init_clock,
            status_in, data_in}),
    .q    ({req_n_s, strobe_s, uclk_s, status_s, data_s})
  );

  reg strobe_prev_q;
  reg uclk_prev_q;
  reg por_started_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_prev_q <= 1'b0;
      uclk_prev_q   <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
      uclk_prev_q   <= uclk_s;
    end
  end

  wire strobe_rise = strobe_s & ~strobe_prev_q;
  wire uclk_rise   = uclk_s & ~uclk_prev_q;

  // ----------------------------------------------------------------
  // shared timer
  // ----------------------------------------------------------------
  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg           tmr_load;
  reg  [TW-1:0] tmr_value;
  reg           tmr_dec;
  wire          tmr_done;

  cfgs_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .load  (tmr_load),
    .value (tmr_value),
    .dec   (tmr_dec),
    .done  (tmr_done)
  );

  // ----------------------------------------------------------------
  // byte counter
  // ----------------------------------------------------------------
  reg  [15:0] byte_cnt_q;
  wire        last_byte = (byte_cnt_q == LAST_IDX);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_value = {TW{1'b0}};
    tmr_dec   = 1'b1;
    case (state_q)
      ST_POR: begin
        if (!por_started_q) begin
          tmr_load  = 1'b1;
          tmr_value = T_POR;
        end else if (tmr_done) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RESET: begin
        if (req_n_s && tmr_done) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (status_s) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (byte_error) begin
          state_d   = ST_ERROR;
          tmr_load  = 1'b1;
          tmr_value = T_STATUS;
        end else if (strobe_rise && last_byte) begin
          tmr_load = 1'b1;
          if (opt_user_init_clk) begin
            state_d   = ST_INIT_CU;
            tmr_value = T_CU;
          end else begin
            state_d   = ST_INIT_OSC;
            tmr_value = T_CD2UM;
          end
        end
      end
      ST_INIT_OSC: begin
        if (tmr_done) begin
          state_d = ST_USER;
        end
      end
      ST_INIT_CU: begin
        if (tmr_done) begin
          state_d   = ST_INIT_USR;
          tmr_load  = 1'b1;
          tmr_value = T_USR;
        end
      end
      ST_INIT_USR: begin
        tmr_dec = uclk_rise;
        if (tmr_done) begin
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        state_d = ST_USER;
      end
      ST_ERROR: begin
        if (tmr_done) begin
          state_d = opt_auto_restart ? ST_RELEASE : ST_ERR_HOLD;
        end
      end
      ST_ERR_HOLD: begin
        state_d = ST_ERR_HOLD;
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    // request low restarts from any state except power-on and reset
    if (!req_n_s && state_q != ST_POR && state_q != ST_RESET) begin
      state_d   = ST_RESET;
      tmr_load  = 1'b1;
      tmr_value = T_STATUS;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q       <= ST_POR;
      por_started_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      por_started_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // byte capture
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byte_cnt_q     <= 16'h0000;
      cfg_byte       <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else begin
      cfg_byte_valid <= 1'b0;
      if (state_q != ST_LOAD) begin
        byte_cnt_q <= 16'h0000;
      end else if (strobe_rise && !byte_error && req_n_s) begin
        cfg_byte       <= data_s;
        cfg_byte_valid <= 1'b1;
        byte_cnt_q     <= byte_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // open drain: the value is always low, only the enable moves
  assign status_out   = 1'b0;
  assign complete_out = 1'b0;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_oe_n   <= 1'b0;
      complete_oe_n <= 1'b0;
      user_mode     <= 1'b0;
      io_tristate   <= 1'b1;
      data_oe_n     <= 1'b1;
      data_out      <= 8'h00;
    end else begin
      // status low in reset, error and power-up
      status_oe_n <= ~(state_d == ST_POR || state_d == ST_RESET ||
                       state_d == ST_ERROR || state_d == ST_ERR_HOLD);
      complete_oe_n <= (state_d == ST_INIT_OSC || state_d == ST_INIT_CU ||
                        state_d == ST_INIT_USR || state_d == ST_USER);
      // both start-up paths end in user mode
      user_mode   <= (state_d == ST_USER);
      io_tristate <= (state_d != ST_USER);
      data_oe_n <= ~(state_d == ST_USER && dual_purpose_io && user_io_oe);
      data_out  <= user_io_out;
    end
  end

endmodule

`default_nettype wire

// ### cfgs_defs.vh
// Purpose: shared constants of the parallel configuration sequencer
// Assumes: 100 MHz system clock
// Notes:   times keep their own unit; cycle counts derive from them
`ifndef CFGS_DEFS_VH
`define CFGS_DEFS_VH

// ----------------------------------------------------------------
// clock and timer
// ----------------------------------------------------------------
`define CFGS_CLK_NS          10
`define CFGS_TMR_W           20
`define CFGS_BYTE_W          8

// ----------------------------------------------------------------
// documented times (least times, rounded up to whole cycles)
// ----------------------------------------------------------------
`define CFGS_POR_US          100
`define CFGS_STATUS_MIN_US   10
`define CFGS_CD2UM_MIN_US    55
`define CFGS_LOAD_STROBE_CLOCK_MAX_PER_PS 12500
`define CFGS_CU_PERIODS      4
`define CFGS_USR_PERIODS     8532
`define CFGS_IMAGE_BYTES     16

`define CFGS_US2CYC(us) (((us) * 1000 + `CFGS_CLK_NS - 1) / `CFGS_CLK_NS)
`define CFGS_POR_CYC        `CFGS_US2CYC(`CFGS_POR_US)
`define CFGS_STATUS_MIN_CYC `CFGS_US2CYC(`CFGS_STATUS_MIN_US)
`define CFGS_CD2UM_CYC      `CFGS_US2CYC(`CFGS_CD2UM_MIN_US)
`define CFGS_CU_CYC \
  ((`CFGS_CU_PERIODS * `CFGS_LOAD_STROBE_CLOCK_MAX_PER_PS + `CFGS_CLK_NS * 1000 - 1) / (`CFGS_CLK_NS * 1000))

`endif

// ### cfgs_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none

module cfgs_sync #(
  parameter W = 1
) (
  input  wire         clk,   // system clock
  input  wire         rstn,  // async reset, active low
  input  wire [W-1:0] d,     // asynchronous input
  output reg  [W-1:0] q      // synchronised output
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### cfgs_timer.v
// Purpose: shared down counter for every timed wait of the sequencer
// Assumes: load has priority over decrement
// Notes:   done is high while the count is zero
`timescale 1ns/1ns
`default_nettype none

module cfgs_timer #(
  parameter W = 20
) (
  input  wire         clk,   // system clock
  input  wire         rstn,  // async reset, active low
  input  wire         load,  // load a new count
  input  wire [W-1:0] value, // count to load
  input  wire         dec,   // decrement enable
  output wire         done   // count has reached zero
);

  reg [W-1:0] cnt_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (dec && cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_q == {W{1'b0}});

endmodule

`default_nettype wire

// ### cfgs_checker.sv
// Purpose: port assertions for cfgs_sequencer
// Assumes: one clock domain, reset active low
// Notes:   status is judged on its drive enable, since others may hold the line
`timescale 1ns/1ns
`default_nettype none
module cfgs_checker #(
  parameter POR_CYC     = 10000, // power-on hold
  parameter CD2UM_CYC   = 5500,  // complete to user mode
  parameter USR_PERIODS = 8532,  // user clock periods
  parameter IMAGE_BYTES = 16     // image length
) (
  input wire logic       clk,               // clock
  input wire logic       rstn,              // reset
  input wire logic       config_request_n,  // pin
  input wire logic       load_strobe_clock, // pin
  input wire logic       user_init_clock,   // pin
  input wire logic [7:0] data_in,           // pin
  input wire logic [7:0] data_out,          // pin
  input wire logic       data_oe_n,         // pin
  input wire logic       status_in,         // line
  input wire logic       status_out,        // line
  input wire logic       status_oe_n,       // line
  input wire logic       complete_in,       // line
  input wire logic       complete_out,      // line
  input wire logic       complete_oe_n,     // line
  input wire logic       opt_user_init_clk, // option
  input wire logic       opt_auto_restart,  // option
  input wire logic       dual_purpose_io,   // option
  input wire logic       byte_error,        // flag
  input wire logic [7:0] user_io_out,       // user
  input wire logic       user_io_oe,        // user
  input wire logic [7:0] cfg_byte,          // byte
  input wire logic       cfg_byte_valid,    // pulse
  input wire logic       user_mode,         // state
  input wire logic       io_tristate        // state
);
  localparam int STAT_MIN = 1000;
  localparam int REL_MAX  = 50000;
  logic [15:0] por_q, low_q, rel_q, cd_q, bcnt_q;
  logic        seen_q, arm_q, req_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {por_q, low_q, rel_q, cd_q, bcnt_q} <= '0;
      {seen_q, arm_q, req_q} <= 3'b001;
    end else begin
      por_q  <= (por_q < 16'(POR_CYC)) ? por_q + 16'h0001 : por_q;
      low_q  <= status_oe_n ? 16'h0000 : low_q + 16'h0001;
      seen_q <= seen_q | status_oe_n;
      req_q  <= config_request_n;
      // armed from the request rising until the status drive lets go
      arm_q  <= !status_oe_n && (arm_q || (config_request_n && !req_q));
      rel_q  <= arm_q ? rel_q + 16'h0001 : 16'h0000;
      cd_q   <= complete_oe_n ? cd_q + 16'h0001 : 16'h0000;
      bcnt_q <= status_oe_n ? bcnt_q + 16'(cfg_byte_valid) : 16'h0000;
    end
  end
  sequence s_req_held;
    !config_request_n [*6];
  endsequence
  sequence s_err_in_load;
    byte_error && status_oe_n && !complete_oe_n && status_in && $past(status_in, 6);
  endsequence
  a_por_hold: assert property (por_q < 16'(POR_CYC) |-> !status_oe_n)
    else $error("status freed inside power-on delay");
  a_status_width: assert property ($rose(status_oe_n) && seen_q |-> low_q >= STAT_MIN)
    else $error("status low pulse too short");
  a_release_bound: assert property (rel_q < REL_MAX)
    else $error("status not freed after request high");
  a_request_low: assert property (s_req_held |-> !status_oe_n && !complete_oe_n && io_tristate && data_oe_n)
    else $error("request low not obeyed");
  a_user_lines: assert property (user_mode |-> status_oe_n && complete_oe_n && !io_tristate)
    else $error("line low in user mode");
  a_done_image: assert property ($rose(complete_oe_n) |-> cfg_byte_valid && bcnt_q == IMAGE_BYTES - 1)
    else $error("complete rose before last byte");
  a_osc_delay: assert property ($rose(user_mode) && !opt_user_init_clk |-> cd_q >= CD2UM_CYC)
    else $error("user mode too soon after complete");
  a_byte_bus: assert property (cfg_byte_valid |-> cfg_byte == $past(data_in, 4))
    else $error("captured byte differs from bus");
  a_error_drop: assert property (s_err_in_load |=> !status_oe_n && !complete_oe_n)
    else $error("error did not pull status low");
endmodule
bind cfgs_sequencer cfgs_checker #(.POR_CYC(POR_CYC), .CD2UM_CYC(CD2UM_CYC),
  .USR_PERIODS(USR_PERIODS), .IMAGE_BYTES(IMAGE_BYTES)) cfgs_checker_i (.*);
`default_nettype wire

// ### cfgs_host.sv
// Purpose: behavioural configuration host on the sequencer pins
// Assumes: caller sees status high before starting a frame
// Notes:   strobe stands low between frames; data then shows the inverted last byte
`timescale 1ns/1ns
`default_nettype none
module cfgs_host (
  output logic       config_request_n,  // request pin
  output logic       load_strobe_clock, // byte strobe
  output logic       user_init_clock,   // user init clock
  output logic [7:0] data_host,         // data bus drive
  input  wire logic  usr_run            // let the user clock run
);
  longint t_req = -1000000;
  initial begin
    config_request_n = 1'b1;
    load_strobe_clock = 1'b0;
    user_init_clock = 1'b0;
    data_host = 8'h00;
  end
  always #80 if (usr_run) user_init_clock = ~user_init_clock;
  // request low at least 2 us
  task automatic request_pulse(input int low_ns);
    config_request_n = 1'b0;
    #(low_ns < 2000 ? 2000 : low_ns);
    config_request_n = 1'b1;
    t_req = longint'($time);
  endtask
  // one plain frame, gap stretches each byte
  task automatic load_image(input logic [7:0] first, input int n, input int gap);
    // the extra ns keeps every strobe and data change off the clock edges
    #2001;
    while (longint'($time) < t_req + 500000) #100;
    for (int i = 0; i < n; i++) begin
      data_host = first + 8'(i);
      #(62 + gap) load_strobe_clock = 1'b1;
      #63 load_strobe_clock = 1'b0;
    end
    data_host = ~data_host;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for cfgs_sequencer
// Assumes: host model drives link pins; bench drives options at falling edges
// Notes:   short counts; the 500 us host wait dominates the run
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int NB = 4;
  localparam int CDUM = 40;
  localparam int USRP = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic opt_user_init_clk = 1'b0, opt_auto_restart = 1'b1, dual_purpose_io = 1'b0;
  logic byte_error = 1'b0, user_io_oe = 1'b0, usr_run = 1'b0;
  logic [7:0] user_io_out = 8'h5a;
  wire logic config_request_n, load_strobe_clock, user_init_clock, status_out, status_oe_n;
  wire logic complete_out, complete_oe_n, data_oe_n, cfg_byte_valid, user_mode, io_tristate;
  wire logic status_in, complete_in;
  wire logic [7:0] data_host, data_out, data_in, cfg_byte;
  int fails = 0, checks_done = 0, k, cdn = 0;
  logic [7:0] got[$];
  // pull-ups on the open-drain lines
  assign status_in = status_oe_n ? 1'b1 : status_out;
  assign complete_in = complete_oe_n ? 1'b1 : complete_out;
  assign data_in = data_oe_n ? data_host : data_out;
  always #5 clk = ~clk;
  always @(negedge clk) if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
  // cycles since the complete line rose, so start-up delays count from that edge
  always @(negedge clk) cdn <= (complete_in === 1'b1) ? cdn + 1 : 0;
  cfgs_sequencer #(.POR_CYC(50), .CD2UM_CYC(CDUM), .USR_PERIODS(USRP), .IMAGE_BYTES(NB))
    cfgs_sequencer_i (.*);
  cfgs_host cfgs_host_i (.*);
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic ready(input int sel);
    return sel == 0 ? status_in === 1'b1 : sel == 1 ? complete_oe_n === 1'b1 : user_mode === 1'b1;
  endfunction
  // leaves the cycle count in k for the caller
  task automatic wait_hi(input int sel, input int lim);
    for (k = 0; k < lim && !ready(sel); k++) @(negedge clk);
    if (k >= lim) begin
      fails++;
      $display("[FAIL] t=%0t wait=%h limit=%h", $time, sel, lim);
      summarize();
    end
  endtask
  task automatic finish_load(input logic [7:0] first, input int lo);
    wait_hi(1, 200);
    cmp(16'(got.size()), 16'(NB));
    for (int i = 0; i < NB; i++) cmp(got[i], first + 8'(i));
    wait_hi(2, 3000);
    cmp(16'(cdn >= lo), 16'h0001);
    cmp({status_in, complete_in, io_tristate}, 3'b110);
  endtask
  // power-up load, error in mid-image, automatic restart, user io
  task automatic t_power_up();
    repeat (45) @(negedge clk);
    cmp({status_in, complete_in}, 2'b00);
    wait_hi(0, 100);
    cfgs_host_i.load_image(8'h10, 2, 0);
    @(negedge clk);
    cmp(16'(got.size()), 16'h0002);
    byte_error = 1'b1;
    @(negedge clk);
    byte_error = 1'b0;
    @(negedge clk);
    cmp({status_in, complete_in}, 2'b00);
    got.delete();
    wait_hi(0, 1200);
    cmp(k >= 990, 16'h0001);
    cfgs_host_i.load_image(8'h40, NB, 0);
    finish_load(8'h40, CDUM);
    dual_purpose_io = 1'b1;
    user_io_oe = 1'b1;
    repeat (3) @(negedge clk);
    cmp({data_oe_n, data_in}, {1'b0, 8'h5a});
  endtask
  // reconfiguration from user mode, start-up on the user clock, slow host
  task automatic t_reconfig();
    opt_user_init_clk = 1'b1;
    usr_run = 1'b1;
    fork
      cfgs_host_i.request_pulse(3000);
      begin
        repeat (50) @(negedge clk);
        cmp({status_in, complete_in, user_mode, io_tristate, data_oe_n}, 5'b00011);
      end
    join
    got.delete();
    wait_hi(0, 50000);
    cfgs_host_i.load_image(8'ha0, NB, 400);
    finish_load(8'ha0, 5 + (USRP - 1) * 16);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_power_up();
    t_reconfig();
    summarize();
  end
endmodule
`default_nettype wire
